/* File: drive_cfg.svh */
// Offsets, field positions, reset values and codes of the power-state block
`ifndef DRIVE_CFG_SVH
`define DRIVE_CFG_SVH

// Device object indices
`define IDX_BOOT        16'h4042
`define IDX_ABORT       16'h6007
`define IDX_LASTERR     16'h603F
`define IDX_CTRL        16'h6040
`define IDX_STAT        16'h6041
`define BOOT_SUB_CNT    8'h03
`define BOOT_SUB_VER    8'h01
`define BOOT_SUB_BUS    8'h02
`define BOOT_SUB_HW     8'h03

// Reset values
`define ABORT_RST       16'hFFFF
`define CTRL_RST        16'h0000
`define STAT_RST        16'h0000
`define LASTERR_RST     16'h0000

// Abort reaction codes
`define AB_ZERO         16'hFFFF
`define AB_NONE         16'h0000
`define AB_FAULT        16'h0001
`define AB_DISV         16'h0002
`define AB_QSTOP        16'h0003

// Control word bits
`define CW_SWON         0
`define CW_VOLT         1
`define CW_QSTOP_N      2
`define CW_OPEN         3
`define CW_FCLR         7
`define CW_HALT         8

// Status word bits
`define SW_READY        0
`define SW_SWON         1
`define SW_OPEN         2
`define SW_FAULT        3
`define SW_VOLT         4
`define SW_QSTOP_N      5
`define SW_DIS          6
`define SW_WARN         7
`define SW_SYNC         8
`define SW_REMOTE       9
`define SW_CLOOP        15

// Modes in which halt acts
`define MODE_PP         8'h01
`define MODE_VL         8'h02
`define MODE_PV         8'h03
`define MODE_TQ         8'h04
`define MODE_IP         8'h07

// Controller APB register offsets
`define APB_CMD         12'h000
`define APB_WDATA       12'h004
`define APB_RDATA       12'h008
`define APB_STAT        12'h00C
`define CMD_GO          31
`define CMD_WE          24

`endif

/* File: drive_pkg.sv */
// Types shared by the power-state device and its controller
package drive_pkg;

    typedef enum logic [2:0] {
        PS_NOT_READY = 3'b000,
        PS_DISABLED  = 3'b001,
        PS_READY     = 3'b010,
        PS_SWITCHED  = 3'b011,
        PS_ENABLED   = 3'b100,
        PS_QSTOP     = 3'b101,
        PS_FREACT    = 3'b110,
        PS_FAULT     = 3'b111
    } pstate_t;

    typedef struct packed {
        logic [2:0]  be_s;
        logic        be_lvl;
        logic [15:0] abort_r;
        logic [15:0] cw;
        logic [15:0] sw;
        logic [15:0] last_err;
        logic        fr_prev;
        logic        warn;
        pstate_t     st;
        logic        ack;
        logic        err;
        logic [31:0] rdata;
        logic        halt;
        logic        power_on;
        logic        drive_on;
    } dev_state_t;

    typedef enum logic [1:0] {
        HC_IDLE = 2'b00,
        HC_REQ  = 2'b01
    } hstate_t;

    typedef struct packed {
        hstate_t     st;
        logic [15:0] idx;
        logic [7:0]  sub;
        logic        we;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        done;
        logic        err;
        logic        req;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } host_state_t;

endpackage

/* File: drive_link_if.sv */
// Object access link between fieldbus controller and power-state device
`timescale 1ns/10ps
`default_nettype none
interface drive_link_if;
    logic        req;
    logic        we;
    logic [15:0] idx;
    logic [7:0]  sub;
    logic [31:0] wdata;
    logic        ack;
    logic        err;
    logic [31:0] rdata;

    modport dev (input req, we, idx, sub, wdata, output ack, err, rdata);
    modport ctl (output req, we, idx, sub, wdata, input ack, err, rdata);
endinterface
`default_nettype wire

/* File: drive_power_state_control.sv */
// Power-state machine, control/status words and abort reaction of the drive
//
// How it works
// RL1: Boot version word: main high, minor low
// RL2: Boot fieldbus word, read only
// RL3: Bus error enters safe-op, applies reaction
// RL4: Code -1 zeroes received values, control word
// RL5: Codes 0..3: none, fault, disable, quick stop
// RL6: Last error is newest history code, low 16
// RL7: Fault reset clears last error code
// RL8: Control bit 0 requests switched on
// RL9: Control bit 1 enables power stage voltage
// RL10: Control bit 2 low forces quick stop
// RL11: Control bit 3 requests operation enabled
// RL12: Control bit 7 clears fault or warning
// RL13: Control bit 8 halts in listed modes
// RL14: Status bit 0 shows ready to switch on
// RL15: Status bit 1 shows switched on
// RL16: Status bit 2 shows operation enabled
// RL17: Status bit 6 shows switched on disabled
// RL18: Status bit 8 shows fieldbus sync
// RL19: Status bit 9 always one; reset loads 16'h0000, so it reads zero during reset
// RL20: Status bit 15: enabled with closed loop
// RL21: Encodes not ready and switch on disabled
// RL22: Encodes ready, switched, enabled, quick stop
// RL23: Encodes fault reaction and fault
// RL24: Only legal transitions change the state
//
// Register access over APB was left to the implementer.
`include "drive_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module drive_power_state_control
    import drive_pkg::*;
#(
    parameter logic [15:0] BOOT_MAIN  = 16'h0001,  // Arbitrary value
    parameter logic [15:0] BOOT_MINOR = 16'h0000,  // Arbitrary value
    parameter logic [31:0] BOOT_BUSES = 32'h0000_0001,  // Arbitrary value
    parameter logic [31:0] BOOT_HW    = 32'h0000_0000   // Arbitrary value
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Object access link
    drive_link_if.dev        lk,
    // Drive side inputs
    input  wire logic        bus_error,
    input  wire logic        sync_ok,
    input  wire logic        closed_loop,
    input  wire logic        voltage_ok,
    input  wire logic        fault_event,
    input  wire logic        fault_present,
    input  wire logic        warn_event,
    input  wire logic        err_valid,
    input  wire logic [15:0] err_code,
    input  wire logic        stop_done,
    input  wire logic [7:0]  op_mode,
    // Drive side outputs
    output logic [15:0]      ctrl_word,
    output logic [15:0]      status_word,
    output logic             halt_motion,
    output logic             power_stage_on,
    output logic             drive_enabled,
    output logic             safe_op
);

    dev_state_t r;
    dev_state_t n;

    logic       fr_rise;
    logic       be_rise;
    logic       shut;
    logic       dis_v;
    logic       qs_req;
    logic       sw_on;
    logic       en_op;
    logic [15:0] cw;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        n = r;
        n.ack = 1'b0;
        n.err = 1'b0;
        n.be_s = {r.be_s[1:0], bus_error};
        be_rise = 1'b0;
        if (r.be_s[1] == r.be_s[2]) begin
            n.be_lvl = r.be_s[2];
            be_rise = r.be_s[2] & ~r.be_lvl;  // see RL3
        end

        // Object access, answered one cycle after the request
        if (lk.req && !r.ack) begin
            n.ack = 1'b1;
            n.rdata = 32'h0000_0000;
            if (lk.idx == `IDX_BOOT && !lk.we) begin
                if (lk.sub == 8'h00) begin
                    n.rdata = {24'h00_0000, `BOOT_SUB_CNT};
                end else if (lk.sub == `BOOT_SUB_VER) begin
                    n.rdata = {BOOT_MAIN, BOOT_MINOR};  // see RL1
                end else if (lk.sub == `BOOT_SUB_BUS) begin
                    n.rdata = BOOT_BUSES;  // see RL2
                end else if (lk.sub == `BOOT_SUB_HW) begin
                    n.rdata = BOOT_HW;
                end else begin
                    n.err = 1'b1;
                end
            end else if (lk.idx == `IDX_ABORT) begin
                n.rdata = {16'h0000, r.abort_r};
                if (lk.we) begin
                    n.abort_r = lk.wdata[15:0];
                end
            end else if (lk.idx == `IDX_LASTERR && !lk.we) begin
                n.rdata = {16'h0000, r.last_err};  // see RL6
            end else if (lk.idx == `IDX_CTRL) begin
                n.rdata = {16'h0000, r.cw};
                if (lk.we) begin
                    n.cw = lk.wdata[15:0];
                end
            end else if (lk.idx == `IDX_STAT && !lk.we) begin
                n.rdata = {16'h0000, r.sw};
            end else begin
                n.err = 1'b1;
            end
        end

        // Received values held at zero while the link is lost under abort code -1
        if (r.be_lvl && r.abort_r == `AB_ZERO) begin
            n.cw = 16'h0000;  // see RL4
        end

        // Fault reset edge clears warning and last error; new events win
        fr_rise = r.cw[`CW_FCLR] & ~r.fr_prev;
        n.fr_prev = r.cw[`CW_FCLR];
        if (fr_rise) begin
            n.warn = 1'b0;  // see RL12
            n.last_err = 16'h0000;  // see RL7
        end
        if (warn_event) begin
            n.warn = 1'b1;
        end
        if (err_valid) begin
            n.last_err = err_code;  // see RL6
        end

        // Command decode
        cw = r.cw;
        dis_v = ~cw[`CW_VOLT];  // see RL9
        qs_req = cw[`CW_VOLT] & ~cw[`CW_QSTOP_N];  // see RL10
        shut = cw[2:0] == 3'b110;
        sw_on = cw[3:0] == 4'b0111;  // see RL8
        en_op = cw[3:0] == 4'b1111;  // see RL11

        // Power state machine, legal transitions only (see RL24)
        case (r.st)
            PS_NOT_READY: n.st = PS_DISABLED;
            PS_DISABLED: begin
                if (shut) begin
                    n.st = PS_READY;
                end
            end
            PS_READY: begin
                if (dis_v || qs_req) begin
                    n.st = PS_DISABLED;
                end else if (en_op) begin
                    n.st = PS_ENABLED;
                end else if (sw_on) begin
                    n.st = PS_SWITCHED;
                end
            end
            PS_SWITCHED: begin
                if (dis_v || qs_req) begin
                    n.st = PS_DISABLED;
                end else if (shut) begin
                    n.st = PS_READY;
                end else if (en_op) begin
                    n.st = PS_ENABLED;  // see RL11
                end
            end
            PS_ENABLED: begin
                if (dis_v) begin
                    n.st = PS_DISABLED;
                end else if (qs_req) begin
                    n.st = PS_QSTOP;  // see RL10
                end else if (shut) begin
                    n.st = PS_READY;
                end else if (sw_on) begin
                    n.st = PS_SWITCHED;
                end
            end
            PS_QSTOP: begin
                if (dis_v || stop_done) begin
                    n.st = PS_DISABLED;
                end
            end
            PS_FREACT: n.st = PS_FAULT;
            default: begin
                if (fr_rise && !fault_present) begin
                    n.st = PS_DISABLED;  // see RL12
                end
            end
        endcase

        // Reaction to a lost link (see RL3)
        if (be_rise) begin
            if (r.abort_r == `AB_FAULT) begin
                n.st = PS_FREACT;  // see RL5
            end else if (r.abort_r == `AB_DISV && r.st != PS_FAULT && r.st != PS_FREACT) begin
                n.st = PS_DISABLED;  // see RL5
            end else if (r.abort_r == `AB_QSTOP) begin
                if (r.st == PS_ENABLED) begin
                    n.st = PS_QSTOP;  // see RL5
                end else if (r.st == PS_READY || r.st == PS_SWITCHED) begin
                    n.st = PS_DISABLED;
                end
            end
        end
        if (fault_event && r.st != PS_FAULT) begin
            n.st = PS_FREACT;
        end

        // Status word from the new state
        n.sw = 16'h0000;
        case (n.st)
            PS_DISABLED: n.sw[6:0] = 7'b100_0000;  // see RL17 RL21
            PS_READY:    n.sw[6:0] = 7'b010_0001;  // see RL14 RL22
            PS_SWITCHED: n.sw[6:0] = 7'b010_0011;  // see RL15 RL22
            PS_ENABLED:  n.sw[6:0] = 7'b010_0111;  // see RL16 RL22
            PS_QSTOP:    n.sw[6:0] = 7'b000_0111;  // see RL22
            PS_FREACT:   n.sw[6:0] = 7'b000_1111;  // see RL23
            PS_FAULT:    n.sw[6:0] = 7'b000_1000;  // see RL23
            default:     n.sw[6:0] = 7'b000_0000;  // see RL21
        endcase
        n.sw[`SW_VOLT] = voltage_ok;
        n.sw[`SW_WARN] = n.warn;
        n.sw[`SW_SYNC] = sync_ok;  // see RL18
        n.sw[`SW_REMOTE] = 1'b1;  // see RL19
        n.sw[`SW_CLOOP] = n.st == PS_ENABLED && closed_loop;  // see RL20

        n.halt = n.cw[`CW_HALT] && (op_mode == `MODE_PP || op_mode == `MODE_VL
                 || op_mode == `MODE_PV || op_mode == `MODE_TQ
                 || op_mode == `MODE_IP);  // see RL13
        n.power_on = n.st == PS_SWITCHED || n.st == PS_ENABLED || n.st == PS_QSTOP
                     || n.st == PS_FREACT;
        n.drive_on = n.st == PS_ENABLED;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.abort_r <= `ABORT_RST;
            r.cw <= `CTRL_RST;
            r.sw <= `STAT_RST;
            r.last_err <= `LASTERR_RST;
            r.st <= PS_NOT_READY;
        end else begin
            r <= n;
        end
    end

    assign lk.ack = r.ack;
    assign lk.err = r.err;
    assign lk.rdata = r.rdata;
    assign ctrl_word = r.cw;
    assign status_word = r.sw;
    assign halt_motion = r.halt;
    assign power_stage_on = r.power_on;
    assign drive_enabled = r.drive_on;
    assign safe_op = r.be_lvl;

endmodule
`default_nettype wire

/* File: drive_fieldbus_master.sv */
// Fieldbus-side controller: APB registers drive object accesses on the link
`include "drive_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module drive_fieldbus_master
    import drive_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // Object access link
    drive_link_if.ctl        lk
);

    host_state_t r;
    host_state_t n;
    logic        acc;
    logic        wr;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        n = r;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        acc = psel && penable && !r.pready;
        if (acc) begin
            n.pready = 1'b1;
            n.prdata = 32'h0000_0000;
            if (paddr == `APB_CMD) begin
                n.prdata = {r.st == HC_REQ, 6'h00, r.we, r.sub, r.idx};
            end else if (paddr == `APB_WDATA) begin
                n.prdata = r.wdata;
            end else if (paddr == `APB_RDATA) begin
                n.prdata = r.rdata;
            end else if (paddr == `APB_STAT) begin
                n.prdata = {29'h0000_0000, r.err, r.done, r.st == HC_REQ};
            end else begin
                n.pslverr = 1'b1;
            end
        end

        // Writes land at the edge that completes the transfer
        wr = psel && penable && pwrite && r.pready && r.st == HC_IDLE;
        if (wr && paddr == `APB_CMD) begin
            n.idx = pwdata[15:0];
            n.sub = pwdata[23:16];
            n.we = pwdata[`CMD_WE];
            if (pwdata[`CMD_GO]) begin
                n.st = HC_REQ;
                n.req = 1'b1;
                n.done = 1'b0;
                n.err = 1'b0;
            end
        end
        if (wr && paddr == `APB_WDATA) begin
            n.wdata = pwdata;
        end

        // Request held until the device answers (see RL7 RL8 RL9 RL10 RL11)
        case (r.st)
            HC_REQ: begin
                if (lk.ack) begin
                    n.st = HC_IDLE;
                    n.req = 1'b0;
                    n.done = 1'b1;
                    n.err = lk.err;
                    n.rdata = lk.rdata;
                end
            end
            default: begin
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.st <= HC_IDLE;
        end else begin
            r <= n;
        end
    end

    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign prdata = r.prdata;
    assign lk.req = r.req;
    assign lk.we = r.we;
    assign lk.idx = r.idx;
    assign lk.sub = r.sub;
    assign lk.wdata = r.wdata;

endmodule
`default_nettype wire

/* File: drive_link_props.sv */
// Link handshake and object-read checks for the power-state pair
`timescale 1ns/10ps
`default_nettype none
`include "drive_cfg.svh"
module drive_link_props (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Link signals
    input wire logic        req,
    input wire logic        we,
    input wire logic [15:0] idx,
    input wire logic [7:0]  sub,
    input wire logic [31:0] wdata,
    input wire logic        ack,
    input wire logic        err,
    input wire logic [31:0] rdata
);
    logic rd;
    assign rd = ack && !we && !err;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----------------------------------------------------------------
    // Handshake and object answers
    // ----------------------------------------------------------------
    property p_ack_next; req && !ack |=> ack; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse; ack |=> !ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_req_hold; req && !ack |=> req && $stable({we, idx, sub, wdata}); endproperty
    a_req_hold: assert property (p_req_hold) else $error("request moved");
    property p_req_drop; ack |=> !req; endproperty
    a_req_drop: assert property (p_req_drop) else $error("request kept");
    property p_ro_write;
        ack && we && (idx inside {`IDX_BOOT, `IDX_LASTERR, `IDX_STAT}) |-> err;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write taken");
    property p_unmapped;
        ack && !(idx inside {`IDX_BOOT, `IDX_ABORT, `IDX_LASTERR, `IDX_CTRL, `IDX_STAT}) |-> err;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped taken");
    property p_boot_count;
        ack && !we && idx == `IDX_BOOT && sub == 8'h00 |-> !err && rdata == 32'h0000_0003;
    endproperty
    a_boot_count: assert property (p_boot_count) else $error("bad entry count");
    property p_stat_remote;
        rd && idx == `IDX_STAT |-> rdata[`SW_REMOTE] && rdata[31:16] == 16'h0000;
    endproperty
    a_stat_remote: assert property (p_stat_remote) else $error("remote bit low");
    property p_stat_code;
        rd && idx == `IDX_STAT |-> (rdata[6] ? rdata[3:0] == 4'h0
            : rdata[3:0] inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'h8});
    endproperty
    a_stat_code: assert property (p_stat_code) else $error("bad state code");
    property p_word_upper;
        rd && (idx inside {`IDX_ABORT, `IDX_LASTERR, `IDX_CTRL}) |-> rdata[31:16] == 16'h0000;
    endproperty
    a_word_upper: assert property (p_word_upper) else $error("upper half set");
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for controller and power-state device joined by the link
`timescale 1ns/10ps
`default_nettype none
`include "drive_cfg.svh"
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, s;
    logic        bus_error, sync_ok, closed_loop, voltage_ok, fault_event, fault_present;
    logic        warn_event, err_valid, stop_done, e, oe;
    logic        halt_motion, power_stage_on, drive_enabled, safe_op;
    logic [15:0] err_code, ctrl_word, status_word;
    logic [7:0]  op_mode;
    int          failures, n_compared;
    localparam logic [7:0]  HM [5] = '{`MODE_PP, `MODE_VL, `MODE_PV, `MODE_TQ, `MODE_IP};
    localparam logic [15:0] AC [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'hFFFF};
    localparam logic [15:0] AX [5] = '{16'h0027, 16'h0008, 16'h0040, 16'h0007, 16'h0040};
    localparam logic [15:0] AM [5] = '{16'h006F, 16'h004F, 16'h004F, 16'h006F, 16'h004F};

    drive_link_if lk ();
    drive_fieldbus_master u_drive_fieldbus_master (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .lk(lk));
    drive_power_state_control #(.BOOT_MAIN(16'h0004), .BOOT_MINOR(16'h0002),
        .BOOT_BUSES(32'h0000_0005), .BOOT_HW(32'h0000_0009)) u_drive_power_state_control (
        .pclk(pclk), .presetn(presetn), .lk(lk), .bus_error(bus_error), .sync_ok(sync_ok),
        .closed_loop(closed_loop), .voltage_ok(voltage_ok), .fault_event(fault_event),
        .fault_present(fault_present), .warn_event(warn_event), .err_valid(err_valid),
        .err_code(err_code), .stop_done(stop_done), .op_mode(op_mode),
        .ctrl_word(ctrl_word), .status_word(status_word), .halt_motion(halt_motion),
        .power_stage_on(power_stage_on), .drive_enabled(drive_enabled), .safe_op(safe_op));
    drive_link_props u_drive_link_props (.pclk(pclk), .presetn(presetn), .req(lk.req),
        .we(lk.we), .idx(lk.idx), .sub(lk.sub), .wdata(lk.wdata), .ack(lk.ack),
        .err(lk.err), .rdata(lk.rdata));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("failures %0d compared %0d", failures, n_compared);
        if (failures == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic stuck;
        failures++;
        $display("[FAIL] %0t wait ran out", $time);
        conclude();
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) stuck();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Object access through the controller; result in q, refusal in oe
    task automatic obj(input logic w, input logic [15:0] x, input logic [7:0] b,
                       input logic [31:0] d);
        int i;
        apb(1'b1, `APB_WDATA, d);
        apb(1'b1, `APB_CMD, {1'b1, 6'h00, w, b, x});
        i = 0;
        do begin
            apb(1'b0, `APB_STAT, 32'h0);
            i++;
        end while (q[1] !== 1'b1 && i < 20);
        if (q[1] !== 1'b1) stuck();
        oe = q[2];
        apb(1'b0, `APB_RDATA, 32'h0);
    endtask

    task automatic cwr(input logic [15:0] v);
        obj(1'b1, `IDX_CTRL, 8'h00, {16'h0, v});
        repeat (2) @(posedge pclk);
        s = {16'h0, status_word};
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        chk({16'h0, status_word}, 32'h0240);
        obj(1'b0, `IDX_STAT, 8'h00, 32'h0); chk(q, 32'h0240);
        obj(1'b0, `IDX_ABORT, 8'h00, 32'h0); chk(q, 32'hFFFF);
        obj(1'b0, `IDX_LASTERR, 8'h00, 32'h0); chk(q, 32'h0);
        obj(1'b0, `IDX_CTRL, 8'h00, 32'h0); chk(q, 32'h0);
        obj(1'b0, `IDX_BOOT, 8'h00, 32'h0); chk(q, 32'h3);
        obj(1'b0, `IDX_BOOT, 8'h01, 32'h0); chk(q, 32'h0004_0002);
        obj(1'b0, `IDX_BOOT, 8'h02, 32'h0); chk(q, 32'h5);
        obj(1'b0, `IDX_BOOT, 8'h03, 32'h0); chk(q, 32'h9);
        obj(1'b1, `IDX_BOOT, 8'h01, 32'h7); chk({31'h0, oe}, 32'h1);
        obj(1'b1, `IDX_STAT, 8'h00, 32'h7); chk({31'h0, oe}, 32'h1);
        obj(1'b0, 16'h6042, 8'h00, 32'h0); chk({31'h0, oe}, 32'h1);
        apb(1'b0, 12'h010, 32'h0); chk({31'h0, e}, 32'h1);
    endtask

    task automatic t_states;
        cwr(16'h000F); chk(s & 32'h6F, 32'h40);
        cwr(16'h0006); chk(s & 32'h6F, 32'h21);
        cwr(16'h0007); chk(s & 32'h6F, 32'h23);
        cwr(16'h000F); chk(s & 32'h6F, 32'h27);
        chk({30'h0, drive_enabled, power_stage_on}, 32'h3);
        closed_loop <= 1'b1;
        sync_ok <= 1'b1;
        voltage_ok <= 1'b1;
        repeat (2) @(posedge pclk);
        chk({16'h0, status_word & 16'h8110}, 32'h8110);
        closed_loop <= 1'b0;
        sync_ok <= 1'b0;
        cwr(16'h010F);
        for (int i = 0; i < 5; i++) begin
            op_mode <= HM[i];
            repeat (3) @(posedge pclk);
            chk({31'h0, halt_motion}, 32'h1);
        end
        op_mode <= 8'h06;
        repeat (3) @(posedge pclk);
        chk({23'h0, halt_motion, status_word[8]}, 32'h0);
        cwr(16'h000B); chk(s & 32'h6F, 32'h07);
        stop_done <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({16'h0, status_word & 16'h004F}, 32'h40);
        stop_done <= 1'b0;
    endtask

    task automatic t_fault;
        warn_event <= 1'b1;
        err_valid <= 1'b1;
        err_code <= 16'h5A31;
        @(posedge pclk);
        warn_event <= 1'b0;
        err_valid <= 1'b0;
        fault_event <= 1'b1;
        @(posedge pclk);
        fault_event <= 1'b0;
        #1 chk({16'h0, status_word & 16'h004F}, 32'h0F);
        @(posedge pclk);
        #1 chk({16'h0, status_word & 16'h00CF}, 32'h88);
        @(posedge pclk);
        obj(1'b0, `IDX_LASTERR, 8'h00, 32'h0); chk(q, 32'h5A31);
        fault_present <= 1'b1;
        cwr(16'h0080); chk(s & 32'h4F, 32'h08);
        fault_present <= 1'b0;
        cwr(16'h0000);
        cwr(16'h0080); chk(s & 32'hCF, 32'h40);
        obj(1'b0, `IDX_LASTERR, 8'h00, 32'h0); chk(q, 32'h0);
    endtask

    task automatic t_abort;
        for (int i = 0; i < 5; i++) begin
            bus_error <= 1'b0;
            repeat (8) @(posedge pclk);
            cwr(16'h0000);
            cwr(16'h0080);
            cwr(16'h0006);
            cwr(16'h000F);
            obj(1'b1, `IDX_ABORT, 8'h00, {16'h0, AC[i]});
            obj(1'b0, `IDX_ABORT, 8'h00, 32'h0); chk(q, {16'h0, AC[i]});
            bus_error <= 1'b1;
            repeat (10) @(posedge pclk);
            chk({16'h0, status_word & AM[i]}, {16'h0, AX[i]});
            chk({31'h0, safe_op}, 32'h1);
            if (AC[i] == 16'hFFFF) chk({16'h0, ctrl_word}, 32'h0);
        end
        bus_error <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, bus_error, sync_ok, closed_loop} = '0;
        {voltage_ok, fault_event, fault_present, warn_event, err_valid, stop_done} = '0;
        {paddr, pwdata, err_code, op_mode} = '0;
        failures = 0;
        n_compared = 0;
        repeat (5) @(posedge pclk);
        chk({ctrl_word, status_word}, 32'h0);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_reset();
        t_states();
        t_fault();
        t_abort();
        conclude();
    end

    initial begin
        repeat (60000) @(posedge pclk);
        stuck();
    end
endmodule
`default_nettype wire
